/* File: gtm_pkg.sv */
// package for the general timer: register offsets, field positions, reset values
// assumes an 8-bit register port with one-cycle read latency
package gtm_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] OFF_CTRL = 3'h0;
	localparam logic [2:0] OFF_MODE = 3'h1;
	localparam logic [2:0] OFF_RLD_LO = 3'h2;
	localparam logic [2:0] OFF_RLD_HI = 3'h3;
	localparam logic [2:0] OFF_CNT_LO = 3'h4;
	localparam logic [2:0] OFF_CNT_HI = 3'h5;
	localparam logic [2:0] OFF_PRESC = 3'h6;
	// control register bit positions
	localparam int B_OVF = 7;
	localparam int B_EXT = 6;
	localparam int B_RXSEL = 5;
	localparam int B_TXSEL = 4;
	localparam int B_EXTEN = 3;
	localparam int B_RUN = 2;
	localparam int B_CSEL = 1;
	localparam int B_CAP = 0;
	// mode register bit positions
	localparam int B_CKOE = 1;
	localparam int B_DOWN_COUNT_ENABLE = 0;
	// reset values, the count limit and the last baud divider step
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [7:0] PRESC_RST = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [3:0] BAUD_DIV_LAST = 4'hf;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} gtm_req_s;
endpackage : gtm_pkg

/* File: gtm_serial_model.sv */
// serial port side of the timer: tallies the receive and transmit baud ticks
// assumes ticks are one-cycle pulses on the timer clock
`timescale 1ns/10ps
`default_nettype none
module gtm_serial_model (
	// clock
	input wire logic i_mclk,
	// ticks from the timer
	input wire logic i_rx_tick,
	input wire logic i_tx_tick,
	// tick totals for the bench
	output var logic [15:0] o_rx_cnt,
	output var logic [15:0] o_tx_cnt
);
	initial o_rx_cnt = '0;
	initial o_tx_cnt = '0;
	always @(posedge i_mclk) begin
		if (i_rx_tick === 1'b1) o_rx_cnt <= o_rx_cnt + 16'h0001;
		if (i_tx_tick === 1'b1) o_tx_cnt <= o_tx_cnt + 16'h0001;
	end
endmodule : gtm_serial_model
`default_nettype wire

/* File: gtm_timer.sv */
// general timer with capture, auto-reload, up/down, baud and clock-out modes
// assumes pins arrive asynchronous and the register master never waits
`timescale 1ns/10ps
`default_nettype none
module gtm_timer (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// register port
	input wire gtm_pkg::gtm_req_s i_req,
	output logic [7:0] o_rdata,
	// pins
	input wire logic i_count_pin,
	input wire logic i_external_trigger_pin,
	output logic o_clock_out_pin,
	output logic o_clock_out_oe,
	// serial port and interrupt
	output logic o_rx_baud_tick,
	output logic o_tx_baud_tick,
	output logic o_overflow_pulse,
	output logic o_irq
);
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [15:0] cnt_r, cnt_nxt, rld_r, rld_nxt;
	logic [7:0] presc_r, presc_nxt, pdiv_r, pdiv_nxt, rdata_nxt;
	logic [3:0] bdiv_r, bdiv_nxt;
	logic clk_out_r, clk_out_nxt, ovp_r, ovp_nxt, baud_r, baud_nxt;
	logic [1:0] tsync_r, csync_r;
	logic tprev_r, cprev_r;
	logic t_fall, c_fall, tick, baud_mode, updown, wrap, ext_hit, clkout_mode;
	logic [1:0] tsync_nxt, csync_nxt;
	logic tprev_nxt, cprev_nxt;

	// two-flop synchronisers; only the second stage feeds edge logic
	always_comb begin
		tsync_nxt = {tsync_r[0], i_external_trigger_pin};
		csync_nxt = {csync_r[0], i_count_pin};
		tprev_nxt = tsync_r[1];
		cprev_nxt = csync_r[1];
	end

	// pins come out of reset as idle high so no false falling edge follows reset
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			tsync_r <= 2'h3;
			csync_r <= 2'h3;
			tprev_r <= 1'b1;
			cprev_r <= 1'b1;
		end else begin
			tsync_r <= tsync_nxt;
			csync_r <= csync_nxt;
			tprev_r <= tprev_nxt;
			cprev_r <= cprev_nxt;
		end
	end

	assign t_fall = tprev_r & ~tsync_r[1];
	assign c_fall = cprev_r & ~csync_r[1];
	assign baud_mode = ctrl_r[gtm_pkg::B_RXSEL] | ctrl_r[gtm_pkg::B_TXSEL];
	assign updown = mode_r[gtm_pkg::B_DOWN_COUNT_ENABLE] & ~ctrl_r[gtm_pkg::B_CAP] & ~baud_mode;
	// timer function: one tick per prescale_value+1 clocks
	assign tick = ctrl_r[gtm_pkg::B_RUN] &
		(ctrl_r[gtm_pkg::B_CSEL] ? c_fall : (pdiv_r == presc_r));
	assign ext_hit = ctrl_r[gtm_pkg::B_EXTEN] & t_fall & ~updown;
	// clock-out rollovers are not interrupt sources, so they leave overflow_flag alone
	assign clkout_mode = mode_r[gtm_pkg::B_CKOE] & ~ctrl_r[gtm_pkg::B_CSEL];

	always_comb begin
		ctrl_nxt = ctrl_r;
		mode_nxt = mode_r;
		cnt_nxt = cnt_r;
		rld_nxt = rld_r;
		presc_nxt = presc_r;
		pdiv_nxt = pdiv_r;
		bdiv_nxt = bdiv_r;
		clk_out_nxt = clk_out_r;
		ovp_nxt = 1'b0;
		baud_nxt = 1'b0;
		wrap = 1'b0;
		rdata_nxt = 8'h00;
		// software writes first, so hardware events below win over a clear
		if (i_req.wr) begin
			unique case (i_req.addr)
				gtm_pkg::OFF_CTRL: ctrl_nxt = i_req.wdata;
				gtm_pkg::OFF_MODE: mode_nxt = i_req.wdata[1:0];
				gtm_pkg::OFF_RLD_LO: rld_nxt[7:0] = i_req.wdata;
				gtm_pkg::OFF_RLD_HI: rld_nxt[15:8] = i_req.wdata;
				gtm_pkg::OFF_CNT_LO: cnt_nxt[7:0] = i_req.wdata;
				gtm_pkg::OFF_CNT_HI: cnt_nxt[15:8] = i_req.wdata;
				gtm_pkg::OFF_PRESC: presc_nxt = i_req.wdata;
				default: ;
			endcase
		end
		if (i_req.rd) begin
			unique case (i_req.addr)
				gtm_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
				gtm_pkg::OFF_MODE: rdata_nxt = {6'h00, mode_r};
				gtm_pkg::OFF_RLD_LO: rdata_nxt = rld_r[7:0];
				gtm_pkg::OFF_RLD_HI: rdata_nxt = rld_r[15:8];
				gtm_pkg::OFF_CNT_LO: rdata_nxt = cnt_r[7:0];
				gtm_pkg::OFF_CNT_HI: rdata_nxt = cnt_r[15:8];
				gtm_pkg::OFF_PRESC: rdata_nxt = presc_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		// prescaler restarts whenever the timer is stopped
		if (!ctrl_r[gtm_pkg::B_RUN] || pdiv_r == presc_r)
			pdiv_nxt = 8'h00;
		else
			pdiv_nxt = pdiv_r + 8'h01;
		if (tick) begin
			if (updown && !tsync_r[1]) begin
				// down count: underflow at the reload value
				if (cnt_r == rld_r) begin
					cnt_nxt = gtm_pkg::CNT_MAX;
					wrap = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end else if (cnt_r == gtm_pkg::CNT_MAX) begin
				wrap = 1'b1;
				// capture mode free-runs through zero; others reload
				if (ctrl_r[gtm_pkg::B_CAP] && !baud_mode)
					cnt_nxt = 16'h0000;
				else
					cnt_nxt = rld_r;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
		if (wrap) begin
			ovp_nxt = 1'b1;
			if (!baud_mode && !clkout_mode)
				ctrl_nxt[gtm_pkg::B_OVF] = 1'b1;
			if (updown)
				ctrl_nxt[gtm_pkg::B_EXT] = ~ctrl_r[gtm_pkg::B_EXT];
			// clock out shares the reload value with baud mode
			if (mode_r[gtm_pkg::B_CKOE] && !ctrl_r[gtm_pkg::B_CSEL])
				clk_out_nxt = ~clk_out_r;
			if (baud_mode) begin
				// divide by 16 toward the serial port
				bdiv_nxt = bdiv_r + 4'h1;
				baud_nxt = (bdiv_r == gtm_pkg::BAUD_DIV_LAST);
			end
		end
		if (ext_hit) begin
			ctrl_nxt[gtm_pkg::B_EXT] = 1'b1;
			if (!baud_mode) begin
				if (ctrl_r[gtm_pkg::B_CAP])
					rld_nxt = cnt_r;
				else
					cnt_nxt = rld_r;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ctrl_r <= gtm_pkg::CTRL_RST;
			mode_r <= gtm_pkg::MODE_RST;
			cnt_r <= gtm_pkg::CNT_RST;
			rld_r <= gtm_pkg::CNT_RST;
			presc_r <= gtm_pkg::PRESC_RST;
			pdiv_r <= 8'h00;
			bdiv_r <= 4'h0;
			clk_out_r <= 1'b0;
			ovp_r <= 1'b0;
			baud_r <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			mode_r <= mode_nxt;
			cnt_r <= cnt_nxt;
			rld_r <= rld_nxt;
			presc_r <= presc_nxt;
			pdiv_r <= pdiv_nxt;
			bdiv_r <= bdiv_nxt;
			clk_out_r <= clk_out_nxt;
			ovp_r <= ovp_nxt;
			baud_r <= baud_nxt;
			o_rdata <= rdata_nxt;
		end
	end

	assign o_clock_out_pin = clk_out_r;
	assign o_clock_out_oe = mode_r[gtm_pkg::B_CKOE] & ~ctrl_r[gtm_pkg::B_CSEL];
	assign o_overflow_pulse = ovp_r;
	assign o_rx_baud_tick = baud_r & ctrl_r[gtm_pkg::B_RXSEL];
	assign o_tx_baud_tick = baud_r & ctrl_r[gtm_pkg::B_TXSEL];
	// external_flag requests nothing in up/down mode
	assign o_irq = ctrl_r[gtm_pkg::B_OVF] | (ctrl_r[gtm_pkg::B_EXT] & ~updown);

	AST_OVF_NOT_BAUD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		baud_mode && !ctrl_r[gtm_pkg::B_OVF] && !(i_req.wr && i_req.addr == gtm_pkg::OFF_CTRL)
		|=> !ctrl_r[gtm_pkg::B_OVF]) else $error("overflow flag set in baud mode");
	AST_OVF_STICKY: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_OVF] && !(i_req.wr && i_req.addr == gtm_pkg::OFF_CTRL)
		|=> ctrl_r[gtm_pkg::B_OVF]) else $error("overflow flag dropped");
	AST_STOP_HOLDS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!ctrl_r[gtm_pkg::B_RUN] && !i_req.wr && !ext_hit |=> $stable(cnt_r)) else $error("count moved while stopped");
	AST_CAP_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && ctrl_r[gtm_pkg::B_CAP] && !baud_mode && !clkout_mode && cnt_r == gtm_pkg::CNT_MAX && !i_req.wr
		|=> cnt_r == 16'h0000 && ctrl_r[gtm_pkg::B_OVF]) else $error("capture wrap wrong");
	AST_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ext_hit && ctrl_r[gtm_pkg::B_CAP] && !baud_mode && !i_req.wr
		|=> rld_r == $past(cnt_r) && ctrl_r[gtm_pkg::B_EXT]) else $error("capture missed");
	AST_UP_RELOAD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && !ctrl_r[gtm_pkg::B_CAP] && !updown && cnt_r == gtm_pkg::CNT_MAX && !i_req.wr && !ext_hit
		|=> cnt_r == $past(rld_r)) else $error("reload missed");
	AST_DOWN_UNDER: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && updown && !tsync_r[1] && cnt_r == rld_r && !i_req.wr
		|=> cnt_r == gtm_pkg::CNT_MAX) else $error("underflow load wrong");
	AST_CLKOUT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		wrap && mode_r[gtm_pkg::B_CKOE] && !ctrl_r[gtm_pkg::B_CSEL]
		|=> o_clock_out_pin != $past(o_clock_out_pin)) else $error("clock out no toggle");
	AST_PRESC: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!ctrl_r[gtm_pkg::B_RUN] |=> pdiv_r == 8'h00) else $error("prescaler not cleared");

	// counting
	AST_UP_STEP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && !(updown && !tsync_r[1]) && cnt_r != gtm_pkg::CNT_MAX && !i_req.wr && !ext_hit
		|=> cnt_r == $past(cnt_r) + 16'h0001) else $error("up step wrong");
	AST_DOWN_STEP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && updown && !tsync_r[1] && cnt_r != rld_r && !i_req.wr
		|=> cnt_r == $past(cnt_r) - 16'h0001) else $error("down step wrong");
	AST_UPDOWN_UP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && updown && tsync_r[1] && cnt_r == gtm_pkg::CNT_MAX && !i_req.wr
		|=> cnt_r == $past(rld_r) && ctrl_r[gtm_pkg::B_OVF]) else $error("up/down overflow wrong");
	AST_UPDOWN_DIR: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && updown && tsync_r[1] && cnt_r != gtm_pkg::CNT_MAX && !i_req.wr
		|=> cnt_r == $past(cnt_r) + 16'h0001) else $error("up/down not counting up");
	AST_FORCED_RELOAD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ext_hit && !ctrl_r[gtm_pkg::B_CAP] && !baud_mode && !i_req.wr
		|=> cnt_r == $past(rld_r) && ctrl_r[gtm_pkg::B_EXT]) else $error("forced reload missed");
	AST_CAP_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_CAP] && !ext_hit && !i_req.wr
		|=> rld_r == $past(rld_r)) else $error("capture value moved");
	AST_STOP_NO_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!ctrl_r[gtm_pkg::B_RUN] |-> !wrap) else $error("wrap while stopped");

	// flags, interrupt and mode reset
	AST_OVF_SET: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		wrap && !baud_mode && !clkout_mode |=> ctrl_r[gtm_pkg::B_OVF]) else $error("overflow flag not set");
	AST_EXT_SET: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ext_hit |=> ctrl_r[gtm_pkg::B_EXT]) else $error("external flag not set");
	AST_EXT_TOGGLE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		wrap && updown
		|=> ctrl_r[gtm_pkg::B_EXT] != $past(ctrl_r[gtm_pkg::B_EXT])) else $error("external flag no toggle");
	AST_UPDOWN_NOEXT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		updown |-> !ext_hit) else $error("pin event in up/down mode");
	AST_EXT_QUIET: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		updown && !ctrl_r[gtm_pkg::B_OVF] |-> !o_irq) else $error("up/down external flag interrupts");
	AST_IRQ_OVF: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_OVF] |-> o_irq) else $error("overflow flag without request");
	AST_IRQ_EXT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_EXT] && !updown |-> o_irq) else $error("external flag without request");
	AST_NO_OVF_CLKOUT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		clkout_mode && !ctrl_r[gtm_pkg::B_OVF] && !(i_req.wr && i_req.addr == gtm_pkg::OFF_CTRL)
		|=> !ctrl_r[gtm_pkg::B_OVF]) else $error("overflow flag set in clock-out mode");
	AST_DOWN_COUNT_ENABLE_RESET: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		$rose(i_rst_b) |-> mode_r == gtm_pkg::MODE_RST) else $error("mode not reset");

	// serial port and clock out
	AST_BAUD_RELOAD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		tick && baud_mode && cnt_r == gtm_pkg::CNT_MAX && !i_req.wr
		|=> cnt_r == $past(rld_r)) else $error("baud reload missed");
	AST_BAUD_EXT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ext_hit && baud_mode && !tick && !i_req.wr
		|=> cnt_r == $past(cnt_r) && rld_r == $past(rld_r) && ctrl_r[gtm_pkg::B_EXT]) else $error("baud pin event wrong");
	AST_BAUD_DIV: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		wrap && baud_mode && bdiv_r == gtm_pkg::BAUD_DIV_LAST |=> baud_r) else $error("baud tick missed");
	AST_BAUD_GAP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!wrap |=> !baud_r) else $error("baud tick without wrap");
	AST_WRAP_PULSE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		wrap |=> o_overflow_pulse) else $error("overflow pulse missed");
	AST_PULSE_ONCE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!wrap |=> !o_overflow_pulse) else $error("overflow pulse without wrap");
	AST_RX_GATE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		o_rx_baud_tick |-> ctrl_r[gtm_pkg::B_RXSEL]) else $error("receive tick not selected");
	AST_TX_GATE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		o_tx_baud_tick |-> ctrl_r[gtm_pkg::B_TXSEL]) else $error("transmit tick not selected");
	AST_CLKOUT_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!wrap |=> o_clock_out_pin == $past(o_clock_out_pin)) else $error("clock out moved without wrap");
	AST_CLKOUT_IDLE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		!clkout_mode |=> o_clock_out_pin == $past(o_clock_out_pin)) else $error("clock out moved while off");
	AST_CLKOUT_OE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		clkout_mode |-> o_clock_out_oe) else $error("clock out not driven");

	// prescaler and pins
	AST_PRESC_STEP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_RUN] && pdiv_r != presc_r
		|=> pdiv_r == $past(pdiv_r) + 8'h01) else $error("prescaler step wrong");
	AST_TIMER_TICK: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_RUN] && !ctrl_r[gtm_pkg::B_CSEL] && pdiv_r == presc_r |-> tick) else $error("tick missed");
	AST_EXT_COUNT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_r[gtm_pkg::B_CSEL] && !c_fall |-> !tick) else $error("count without input edge");
endmodule : gtm_timer
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the general timer
// assumes the timer answers reads one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic i_mclk = 0, i_rst_b = 0, cpin = 1, tpin = 1, ck, oe, rxt, txt, ovp, irq;
	gtm_pkg::gtm_req_s req = '0;
	logic [7:0] rdata, p;
	logic [15:0] rxc, txc, v, rl;
	int err_total = 0, samples_checked = 0, seed = 72863, n, k;
	always #25 i_mclk = ~i_mclk;
	gtm_timer DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req), .o_rdata(rdata), .i_count_pin(cpin),
		.i_external_trigger_pin(tpin), .o_clock_out_pin(ck), .o_clock_out_oe(oe), .o_rx_baud_tick(rxt),
		.o_tx_baud_tick(txt), .o_overflow_pulse(ovp), .o_irq(irq));
	gtm_serial_model PTR (.i_mclk(i_mclk), .i_rx_tick(rxt), .i_tx_tick(txt), .o_rx_cnt(rxc), .o_tx_cnt(txc));
	function automatic logic [15:0] per(input logic [15:0] r, input logic [7:0] q);
		return 16'((32'h10000 - 32'(r)) * (32'(q) + 1));
	endfunction : per
	task rst;
		tpin <= 1'b1;
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
	endtask : rst
	// a spare cycle after each strobe keeps a driver from assigning twice in one step
	task wr(input logic [2:0] a, input logic [7:0] d);
		req <= {2'b10, a, d};
		@(posedge i_mclk);
		req <= '0;
		@(posedge i_mclk);
	endtask : wr
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task rdchk(input logic [2:0] a, input logic [15:0] exp);
		req <= {2'b01, a, 8'h00};
		@(posedge i_mclk);
		req <= '0;
		@(negedge i_mclk);
		chk({8'h00, rdata}, exp);
		@(posedge i_mclk);
	endtask : rdchk
	// s: 0 wrap pulse, 1 receive tick, 2 clock-out change; c is cycles waited
	task wait_ev(input int s, output int c);
		logic c0;
		c0 = ck;
		c = 0;
		do begin
			@(negedge i_mclk);
			c++;
		end while (((s == 0) ? ovp : (s == 1) ? rxt : (ck ^ c0)) !== 1'b1 && c < 20000);
		if (c >= 20000) begin
			err_total++;
			$display("[ERR] %0t event wait timed out", $time);
		end
		@(posedge i_mclk);
	endtask : wait_ev
	task wrap_up;
		$display("TB: errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (60000) @(posedge i_mclk);
		err_total++;
		wrap_up;
	end
	initial begin
		rst;
		rdchk(gtm_pkg::OFF_CTRL, 16'h0000);
		rdchk(gtm_pkg::OFF_MODE, 16'h0000);
		rdchk(3'h7, 16'h0000);
		$display("TB: reset test done");
		rl = 16'hffc0 | 16'($random(seed) & 32'h1f);
		p = 8'($random(seed) & 32'h3);
		wr(gtm_pkg::OFF_RLD_LO, rl[7:0]);
		wr(gtm_pkg::OFF_RLD_HI, rl[15:8]);
		wr(gtm_pkg::OFF_PRESC, p);
		wr(gtm_pkg::OFF_CNT_HI, 8'hff);
		wr(gtm_pkg::OFF_CTRL, 8'h04);
		wait_ev(0, n);
		wait_ev(0, n);
		chk(16'(n), per(rl, p));
		chk({15'h0, irq}, 16'h0001);
		rdchk(gtm_pkg::OFF_CTRL, 16'h0084);
		wr(gtm_pkg::OFF_CTRL, 8'h00);
		rdchk(gtm_pkg::OFF_CTRL, 16'h0000);
		rdchk(gtm_pkg::OFF_CNT_HI, 16'h00ff);
		$display("TB: auto-reload test done");
		rst;
		wr(gtm_pkg::OFF_MODE, 8'h01);
		tpin <= 1'b0;
		wr(gtm_pkg::OFF_RLD_LO, 8'hf0);
		wr(gtm_pkg::OFF_RLD_HI, 8'hff);
		wr(gtm_pkg::OFF_CNT_LO, 8'hf8);
		wr(gtm_pkg::OFF_CNT_HI, 8'hff);
		wr(gtm_pkg::OFF_PRESC, 8'hff);
		wr(gtm_pkg::OFF_CTRL, 8'h04);
		wait_ev(0, n);
		rdchk(gtm_pkg::OFF_CTRL, 16'h00c4);
		rdchk(gtm_pkg::OFF_CNT_HI, 16'h00ff);
		wr(gtm_pkg::OFF_CTRL, 8'h44);
		chk({15'h0, irq}, 16'h0000);
		wait_ev(0, n);
		rdchk(gtm_pkg::OFF_CTRL, 16'h0084);
		$display("TB: up-down test done");
		rst;
		wr(gtm_pkg::OFF_CNT_HI, 8'hff);
		wr(gtm_pkg::OFF_CNT_LO, 8'he0);
		wr(gtm_pkg::OFF_CTRL, 8'h0d);
		tpin <= 1'b0;
		repeat (6) @(posedge i_mclk);
		rdchk(gtm_pkg::OFF_CTRL, 16'h004d);
		rdchk(gtm_pkg::OFF_RLD_HI, 16'h00ff);
		wait_ev(0, n);
		rdchk(gtm_pkg::OFF_CTRL, 16'h00cd);
		chk({15'h0, irq}, 16'h0001);
		$display("TB: capture test done");
		rst;
		wr(gtm_pkg::OFF_RLD_LO, 8'hf8);
		wr(gtm_pkg::OFF_RLD_HI, 8'hff);
		wr(gtm_pkg::OFF_CNT_HI, 8'hff);
		wr(gtm_pkg::OFF_MODE, 8'h02);
		wr(gtm_pkg::OFF_CTRL, 8'h34);
		chk({15'h0, oe}, 16'h0001);
		wait_ev(2, n);
		wait_ev(2, n);
		chk(16'(n), per(16'hfff8, 8'h00));
		wait_ev(1, n);
		wait_ev(1, n);
		chk(16'(n), 16'h0010 * per(16'hfff8, 8'h00));
		chk(txc, rxc);
		rdchk(gtm_pkg::OFF_CTRL, 16'h0034);
		chk({15'h0, irq}, 16'h0000);
		wr(gtm_pkg::OFF_CTRL, 8'h2c);
		tpin <= 1'b0;
		v = txc;
		wait_ev(1, n);
		wait_ev(1, n);
		chk(txc, v);
		chk(16'(n), 16'h0010 * per(16'hfff8, 8'h00));
		rdchk(gtm_pkg::OFF_CTRL, 16'h006c);
		wr(gtm_pkg::OFF_CTRL, 8'h04);
		wait_ev(2, n);
		wait_ev(2, n);
		chk(16'(n), per(16'hfff8, 8'h00));
		rdchk(gtm_pkg::OFF_CTRL, 16'h0004);
		chk({15'h0, irq}, 16'h0000);
		$display("TB: baud and clock-out test done");
		rst;
		wr(gtm_pkg::OFF_CTRL, 8'h06);
		n = 1 + ($random(seed) & 15);
		for (k = 0; k < n; k++) begin
			cpin <= 1'b0;
			repeat (2) @(posedge i_mclk);
			cpin <= 1'b1;
			repeat (2) @(posedge i_mclk);
		end
		repeat (6) @(posedge i_mclk);
		rdchk(gtm_pkg::OFF_CNT_LO, 16'(n));
		$display("TB: counter test done");
		wrap_up;
	end
endmodule : tb
`default_nettype wire
